// ===== src/efsu_event_unit.sv
// efsu_event_unit: sticky event flags, enables, live status and the
// interrupt pin of the power manager, behind the serial register port.
// assumes: the serial port slave gives one-cycle rd/wr strobes with the
// address; monitor levels and strobes are synchronous to clock.
//
// Overview of operation
// RULE1: enabled event sets its flag, raises interrupt
// RULE2: flags and interrupt hold until register read
// RULE3: charger connect or disconnect sets low bit 7
// RULE4: discharge temperature window crossing sets bit 6
// RULE5: serial enables keep working after strap reversion
// RULE6: charge temperature window crossing sets bit 5
// RULE7: source low event, mode dependent, sets bit 4
// RULE8: overcharge threshold crossing either way sets bit 3
// RULE9: charge ready threshold crossing sets bit 2
// RULE10: overdischarge after delay or on recovery, bit 1
// RULE11: serial port becoming ready sets bit 0
// RULE12: power monitor error sets high bit 7
// RULE13: power monitor results available sets high bit 6
// RULE14: temperature and storage sample done, bits 5,4
// RULE15: tracking begin bit 0, done bit 1
// RULE16: voltage status bit 5 shows charger presence live
// RULE17: voltage status bit 3 shows source low
// RULE18: voltage status bits 2,1 show storage thresholds
// RULE19: voltage status bit 0 shows qualified overdischarge
// RULE20: temperature status bits 3,2 discharge hot, cold
// RULE21: temperature status bits 1,0 charge hot, cold
// RULE22: two enable registers gate each event bit
// RULE23: result ready after count plus one windows
// RULE24: interrupt is OR of all flag bits
// RULE25: event beats same-cycle read clear; reserved read zero
`timescale 1ns/100ps
`include "efsu_defines.svh"
module efsu_event_unit #(
  parameter int unsigned CRIT_CYCLES =
    `EFSU_CRIT_DELAY_US * `EFSU_CLK_MHZ
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // serial register port
  input wire efsu_pkg::efsu_byte_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire efsu_pkg::efsu_byte_t reg_wdata,
  output efsu_pkg::efsu_byte_t reg_rdata,
  output logic reg_rdata_valid,
  // live monitor levels
  input wire logic aux_charger_present,
  input wire logic discharge_hot_level,
  input wire logic discharge_cold_level,
  input wire logic charge_hot_level,
  input wire logic charge_cold_level,
  input wire logic source_low_level,
  input wire logic overcharge_level,
  input wire logic charge_ready_level,
  input wire logic storage_below_overdischarge,
  input wire logic serial_port_ready,
  input wire logic tracking_ratio_mode,
  // one-cycle event strobes
  input wire logic cv_target_below_low,
  input wire logic power_monitor_error,
  input wire logic power_monitor_window_done,
  input wire logic temperature_sample_done,
  input wire logic storage_sample_done,
  input wire logic tracking_eval_begin,
  input wire logic tracking_eval_done,
  // interrupt pin
  output logic irq_out
);

  // decode shared by the read, write and clear paths
  function automatic logic addr_is(input efsu_pkg::efsu_byte_t addr,
                                   input efsu_pkg::efsu_byte_t off);
    addr_is = (addr == off);
  endfunction

  logic overdischarge_level;
  logic power_monitor_result_ready;
  logic [10:0] level_now;
  logic [10:0] level_prev_reg;
  logic [10:0] level_rise;
  logic [10:0] level_fall;
  logic [10:0] level_toggle;
  logic primed_reg;
  efsu_pkg::efsu_byte_t event_enable_low_reg;
  efsu_pkg::efsu_byte_t event_enable_high_reg;
  efsu_pkg::efsu_byte_t window_accumulate_count_reg;
  efsu_pkg::efsu_events_t raw_event;
  efsu_pkg::efsu_events_t enable_vec;
  efsu_pkg::efsu_events_t clear_vec;
  efsu_pkg::efsu_events_t valid_vec;
  efsu_pkg::efsu_events_t flag_reg;
  efsu_pkg::efsu_byte_t live_status_voltage;
  efsu_pkg::efsu_byte_t live_status_temperature;
  logic rd_flags_low;
  logic rd_flags_high;

  efsu_crit_delay #(
    .CRIT_CYCLES(CRIT_CYCLES)
  ) u_crit_delay (
    .clock(clock),
    .rst_n(rst_n),
    .below_raw(storage_below_overdischarge),
    .overdischarge_level(overdischarge_level)
  );

  efsu_window_accum u_window_accum (
    .clock(clock),
    .rst_n(rst_n),
    .window_done(power_monitor_window_done),
    .window_accumulate_count(window_accumulate_count_reg),
    .result_ready(power_monitor_result_ready)
  );

  // level sampling for crossing detection
  always_comb begin
    level_now = `EFSU_RST_LEVELS;
    level_now[`EFSU_LV_CHARGER] = aux_charger_present;
    level_now[`EFSU_LV_DIS_HOT] = discharge_hot_level;
    level_now[`EFSU_LV_DIS_COLD] = discharge_cold_level;
    level_now[`EFSU_LV_CHG_HOT] = charge_hot_level;
    level_now[`EFSU_LV_CHG_COLD] = charge_cold_level;
    level_now[`EFSU_LV_SRC_LOW] = source_low_level;
    level_now[`EFSU_LV_OVER_CHG] = overcharge_level;
    level_now[`EFSU_LV_CHG_READY] = charge_ready_level;
    level_now[`EFSU_LV_UNDER_VOLT] = overdischarge_level;
    level_now[`EFSU_LV_RAW_BELOW] = storage_below_overdischarge;
    level_now[`EFSU_LV_PORT_RDY] = serial_port_ready;
  end

  // the first cycle after reset only primes the history, otherwise a
  // level that is already high would fake a crossing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      level_prev_reg <= `EFSU_RST_LEVELS;
      primed_reg <= 1'b0;
    end else begin
      level_prev_reg <= level_now;
      primed_reg <= 1'b1;
    end
  end

  assign level_rise = level_now & ~level_prev_reg & {11{primed_reg}};
  assign level_fall = ~level_now & level_prev_reg & {11{primed_reg}};
  assign level_toggle = level_rise | level_fall;

  // raw events before enabling
  always_comb begin
    raw_event = `EFSU_RST_FLAGS;
    raw_event[`EFSU_EV_CHARGER] =
      level_toggle[`EFSU_LV_CHARGER]; // see RULE3
    raw_event[`EFSU_EV_DIS_TEMP] = level_toggle[`EFSU_LV_DIS_HOT] |
      level_toggle[`EFSU_LV_DIS_COLD]; // see RULE4
    raw_event[`EFSU_EV_CHG_TEMP] = level_toggle[`EFSU_LV_CHG_HOT] |
      level_toggle[`EFSU_LV_CHG_COLD]; // see RULE6
    // ratio mode watches the comparator, constant-voltage mode the
    // target check strobe
    raw_event[`EFSU_EV_SRC_LOW] = tracking_ratio_mode ?
      level_rise[`EFSU_LV_SRC_LOW] : cv_target_below_low; // see RULE7
    raw_event[`EFSU_EV_OVER_CHG] =
      level_toggle[`EFSU_LV_OVER_CHG]; // see RULE8
    raw_event[`EFSU_EV_CHG_READY] =
      level_toggle[`EFSU_LV_CHG_READY]; // see RULE9
    // delayed on the way down, immediate on recovery
    raw_event[`EFSU_EV_UNDER_VOLT] = level_rise[`EFSU_LV_UNDER_VOLT] |
      level_fall[`EFSU_LV_RAW_BELOW]; // see RULE10
    raw_event[`EFSU_EV_PORT_RDY] =
      level_rise[`EFSU_LV_PORT_RDY]; // see RULE11
    raw_event[`EFSU_EV_PM_ERR] = power_monitor_error; // see RULE12
    raw_event[`EFSU_EV_PM_DONE] =
      power_monitor_result_ready; // see RULE13
    raw_event[`EFSU_EV_TEMP_DONE] =
      temperature_sample_done; // see RULE14
    raw_event[`EFSU_EV_STO_DONE] = storage_sample_done; // see RULE14
    raw_event[`EFSU_EV_EVAL_DONE] = tracking_eval_done; // see RULE15
    raw_event[`EFSU_EV_EVAL_BEGIN] =
      tracking_eval_begin; // see RULE15
  end

  // enable and configuration registers; the pin-strap update control is
  // not looked at, so serial enables survive a return to strap setup
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      event_enable_low_reg <= `EFSU_RST_EN_LOW;
      event_enable_high_reg <= `EFSU_RST_EN_HIGH;
      window_accumulate_count_reg <= `EFSU_RST_ACCUM;
    end else if (reg_wr) begin
      if (addr_is(reg_addr, `EFSU_OFF_EN_LOW)) begin
        event_enable_low_reg <= reg_wdata; // see RULE22, RULE5
      end else if (addr_is(reg_addr, `EFSU_OFF_EN_HIGH)) begin
        // reserved bits ignore writes
        event_enable_high_reg <= reg_wdata & `EFSU_HIGH_MASK; // see RULE22
      end else if (addr_is(reg_addr, `EFSU_OFF_ACCUM)) begin
        window_accumulate_count_reg <= reg_wdata;
      end
    end
  end

  assign rd_flags_low = reg_rd && addr_is(reg_addr, `EFSU_OFF_FLG_LOW);
  assign rd_flags_high = reg_rd && addr_is(reg_addr, `EFSU_OFF_FLG_HIGH);
  assign enable_vec = {event_enable_low_reg, event_enable_high_reg};
  assign clear_vec = {{8{rd_flags_low}}, {8{rd_flags_high}}};
  assign valid_vec = {8'hFF, `EFSU_HIGH_MASK};

  // one sticky flag per event; set outranks the read clear so an event
  // landing in the read cycle shows up on the next read
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_flag
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          flag_reg[gi] <= 1'b0;
        end else if (raw_event[gi] && enable_vec[gi] && valid_vec[gi]) begin
          flag_reg[gi] <= 1'b1; // see RULE1, RULE25
        end else if (clear_vec[gi]) begin
          flag_reg[gi] <= 1'b0; // see RULE2
        end
      end
    end
  endgenerate

  // interrupt follows the flags, so it holds until every flag is read
  assign irq_out = |flag_reg; // see RULE24, RULE2

  // live status, reserved bits zero
  always_comb begin
    live_status_voltage = `EFSU_RST_BYTE;
    live_status_voltage[`EFSU_ST_CHARGER] = aux_charger_present; // see RULE16
    live_status_voltage[`EFSU_ST_SRC_LOW] = source_low_level; // see RULE17
    live_status_voltage[`EFSU_ST_OVER_CHG] = overcharge_level; // see RULE18
    live_status_voltage[`EFSU_ST_CHG_READY] =
      charge_ready_level; // see RULE18
    live_status_voltage[`EFSU_ST_UNDER_VOLT] =
      overdischarge_level; // see RULE19
    live_status_temperature = `EFSU_RST_BYTE;
    live_status_temperature[`EFSU_ST_DIS_HOT] =
      discharge_hot_level; // see RULE20
    live_status_temperature[`EFSU_ST_DIS_COLD] =
      discharge_cold_level; // see RULE20
    live_status_temperature[`EFSU_ST_CHG_HOT] =
      charge_hot_level; // see RULE21
    live_status_temperature[`EFSU_ST_CHG_COLD] =
      charge_cold_level; // see RULE21
  end

  // read data registered one cycle after the strobe; flags are returned
  // as they stood before the clear
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= `EFSU_RST_BYTE;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_rd;
      if (reg_rd) begin
        if (addr_is(reg_addr, `EFSU_OFF_ACCUM)) begin
          reg_rdata <= window_accumulate_count_reg;
        end else if (addr_is(reg_addr, `EFSU_OFF_EN_LOW)) begin
          reg_rdata <= event_enable_low_reg;
        end else if (addr_is(reg_addr, `EFSU_OFF_EN_HIGH)) begin
          reg_rdata <= event_enable_high_reg;
        end else if (rd_flags_low) begin
          reg_rdata <= flag_reg[15:8];
        end else if (rd_flags_high) begin
          reg_rdata <= flag_reg[7:0] & `EFSU_HIGH_MASK; // see RULE25
        end else if (addr_is(reg_addr, `EFSU_OFF_STAT_VOLT)) begin
          reg_rdata <= live_status_voltage;
        end else if (addr_is(reg_addr, `EFSU_OFF_STAT_TEMP)) begin
          reg_rdata <= live_status_temperature;
        end else begin
          reg_rdata <= `EFSU_RST_BYTE;
        end
      end
    end
  end

endmodule

// ===== src/efsu_defines.svh
// efsu_defines.svh: offsets, bit positions, reset values and timing
// figures of the event flag and status unit.
// assumes: included by bare name from every efsu module source file.
`ifndef EFSU_DEFINES_SVH
`define EFSU_DEFINES_SVH

// register offsets on the serial register port
`define EFSU_OFF_ACCUM 8'h14
`define EFSU_OFF_EN_LOW 8'h15
`define EFSU_OFF_EN_HIGH 8'h16
`define EFSU_OFF_FLG_LOW 8'h18
`define EFSU_OFF_FLG_HIGH 8'h19
`define EFSU_OFF_STAT_VOLT 8'h1A
`define EFSU_OFF_STAT_TEMP 8'h1B

// reset values
`define EFSU_RST_ACCUM 8'h00
`define EFSU_RST_EN_LOW 8'h01
`define EFSU_RST_EN_HIGH 8'h00
`define EFSU_RST_BYTE 8'h00
`define EFSU_RST_FLAGS 16'h0000
`define EFSU_RST_LEVELS 11'h000

// implemented bits of the high enable and flag registers (3:2 reserved)
`define EFSU_HIGH_MASK 8'hF3

// event positions in the joined 16-bit flag vector (high byte = flags low)
`define EFSU_EV_CHARGER 15
`define EFSU_EV_DIS_TEMP 14
`define EFSU_EV_CHG_TEMP 13
`define EFSU_EV_SRC_LOW 12
`define EFSU_EV_OVER_CHG 11
`define EFSU_EV_CHG_READY 10
`define EFSU_EV_UNDER_VOLT 9
`define EFSU_EV_PORT_RDY 8
`define EFSU_EV_PM_ERR 7
`define EFSU_EV_PM_DONE 6
`define EFSU_EV_TEMP_DONE 5
`define EFSU_EV_STO_DONE 4
`define EFSU_EV_EVAL_DONE 1
`define EFSU_EV_EVAL_BEGIN 0

// positions in the sampled level vector
`define EFSU_LV_CHARGER 10
`define EFSU_LV_DIS_HOT 9
`define EFSU_LV_DIS_COLD 8
`define EFSU_LV_CHG_HOT 7
`define EFSU_LV_CHG_COLD 6
`define EFSU_LV_SRC_LOW 5
`define EFSU_LV_OVER_CHG 4
`define EFSU_LV_CHG_READY 3
`define EFSU_LV_UNDER_VOLT 2
`define EFSU_LV_RAW_BELOW 1
`define EFSU_LV_PORT_RDY 0

// bit positions in the live status registers
`define EFSU_ST_CHARGER 5
`define EFSU_ST_SRC_LOW 3
`define EFSU_ST_OVER_CHG 2
`define EFSU_ST_CHG_READY 1
`define EFSU_ST_UNDER_VOLT 0
`define EFSU_ST_DIS_HOT 3
`define EFSU_ST_DIS_COLD 2
`define EFSU_ST_CHG_HOT 1
`define EFSU_ST_CHG_COLD 0

// timing
`define EFSU_CLK_MHZ 100
`define EFSU_CRIT_DELAY_US 1000

`endif

// ===== src/efsu_pkg.sv
// efsu_pkg: shared types of the event flag and status unit.
// assumes: nothing; referenced as efsu_pkg::name.
package efsu_pkg;

  typedef logic [7:0] efsu_byte_t;

  typedef logic [15:0] efsu_events_t;

  typedef enum logic [1:0] {
    EFSU_CRIT_ABOVE,
    EFSU_CRIT_TIMING,
    EFSU_CRIT_UNDER
  } efsu_crit_state_t;

endpackage

// ===== src/efsu_crit_delay.sv
// efsu_crit_delay: qualifies the raw under-voltage comparator with the
// critical undervolt delay.
// assumes: below_raw is synchronous to clock.
`timescale 1ns/100ps
`include "efsu_defines.svh"
module efsu_crit_delay #(
  parameter int unsigned CRIT_CYCLES = 100000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // comparator
  input wire logic below_raw,
  // qualified level
  output logic overdischarge_level
);

  efsu_pkg::efsu_crit_state_t state_reg;
  logic [31:0] count_reg;

  // level asserts only after more than the delay spent at or below
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_reg <= efsu_pkg::EFSU_CRIT_ABOVE;
      count_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        efsu_pkg::EFSU_CRIT_ABOVE: begin
          count_reg <= 32'h0000_0000;
          if (below_raw) begin
            state_reg <= efsu_pkg::EFSU_CRIT_TIMING;
          end
        end
        efsu_pkg::EFSU_CRIT_TIMING: begin
          if (!below_raw) begin
            state_reg <= efsu_pkg::EFSU_CRIT_ABOVE;
          end else if (count_reg >= CRIT_CYCLES - 32'd1) begin
            state_reg <= efsu_pkg::EFSU_CRIT_UNDER; // see RULE19
          end else begin
            count_reg <= count_reg + 32'd1;
          end
        end
        default: begin
          if (!below_raw) begin
            state_reg <= efsu_pkg::EFSU_CRIT_ABOVE;
          end
        end
      endcase
    end
  end

  assign overdischarge_level = (state_reg == efsu_pkg::EFSU_CRIT_UNDER);

endmodule

// ===== src/efsu_window_accum.sv
// efsu_window_accum: counts average power monitor windows and raises
// the result-ready pulse after count plus one of them.
// assumes: window_done is a one-cycle pulse per finished window.
`timescale 1ns/100ps
`include "efsu_defines.svh"
module efsu_window_accum (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // window strobe and configuration
  input wire logic window_done,
  input wire efsu_pkg::efsu_byte_t window_accumulate_count,
  // result
  output logic result_ready
);

  efsu_pkg::efsu_byte_t done_cnt_reg;

  // >= so that lowering the count mid-run cannot strand the counter
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      done_cnt_reg <= `EFSU_RST_BYTE;
      result_ready <= 1'b0;
    end else begin
      result_ready <= 1'b0;
      if (window_done) begin
        if (done_cnt_reg >= window_accumulate_count) begin
          done_cnt_reg <= `EFSU_RST_BYTE;
          result_ready <= 1'b1; // see RULE23
        end else begin
          done_cnt_reg <= done_cnt_reg + 8'h01;
        end
      end
    end
  end

endmodule

// ===== verification/efsu_event_unit_props.sv
// efsu_event_unit_props: port checks for the event flag unit.
// assumes: bound to efsu_event_unit; one clock, synchronous reset.
`timescale 1ns/100ps
module efsu_event_unit_props #(
  parameter int unsigned CRIT_CYCLES = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire efsu_pkg::efsu_byte_t reg_addr,
  input wire logic reg_rd,
  input wire efsu_pkg::efsu_byte_t reg_rdata,
  input wire logic reg_rdata_valid,
  // levels and pin
  input wire logic aux_charger_present,
  input wire logic discharge_hot_level,
  input wire logic discharge_cold_level,
  input wire logic charge_hot_level,
  input wire logic charge_cold_level,
  input wire logic source_low_level,
  input wire logic overcharge_level,
  input wire logic charge_ready_level,
  input wire logic storage_below_overdischarge,
  input wire logic irq_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic flag_rd;
  assign flag_rd = reg_rd && (reg_addr == 8'h18 || reg_addr == 8'h19);
  sequence rd_at(a);
    reg_rd && reg_addr == a;
  endsequence
  // two clear edges, so the delayed level has surely been dropped
  sequence raw_clear;
    !storage_below_overdischarge [*2];
  endsequence
  read_answer_a:
    assert property (reg_rd |=> reg_rdata_valid)
    else $error("read not answered");
  answer_cause_a:
    assert property (reg_rdata_valid |-> $past(reg_rd))
    else $error("answer without read");
  rdata_hold_a:
    assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  irq_hold_a:
    assert property (irq_out && !flag_rd |=> irq_out)
    else $error("irq dropped without flag read");
  volt_status_a:
    assert property (rd_at(8'h1A) |=> reg_rdata[7:1] == {2'b00,
      $past(aux_charger_present), 1'b0, $past(source_low_level),
      $past(overcharge_level), $past(charge_ready_level)})
    else $error("voltage status wrong");
  temp_status_a:
    assert property (rd_at(8'h1B) |=> reg_rdata == {4'h0,
      $past(discharge_hot_level), $past(discharge_cold_level),
      $past(charge_hot_level), $past(charge_cold_level)})
    else $error("temperature status wrong");
  reserved_zero_a:
    assert property ((rd_at(8'h19) or rd_at(8'h16)) |=>
      reg_rdata[3:2] == 2'b00)
    else $error("reserved bits set");
  unmapped_zero_a:
    assert property (reg_rd && reg_addr[7:5] != 3'b000 |=>
      reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  undervolt_clear_a:
    assert property (raw_clear ##0 rd_at(8'h1A) |=> !reg_rdata[0])
    else $error("overdischarge status stuck");
  // run of comparator samples, saturating, to time the qualified level
  logic [31:0] below_cnt;
  always_ff @(posedge clock) begin
    if (!rst_n || !storage_below_overdischarge) begin
      below_cnt <= 32'h0000_0000;
    end else if (below_cnt != 32'hFFFF_FFFF) begin
      below_cnt <= below_cnt + 32'h0000_0001;
    end
  end
  undervolt_delay_a:
    assert property (rd_at(8'h1A) |=>
      reg_rdata[0] == ($past(below_cnt) > CRIT_CYCLES))
    else $error("overdischarge status timing wrong");
endmodule

bind efsu_event_unit efsu_event_unit_props #(
  .CRIT_CYCLES(CRIT_CYCLES)
) i_props (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
  .aux_charger_present(aux_charger_present),
  .discharge_hot_level(discharge_hot_level),
  .discharge_cold_level(discharge_cold_level),
  .charge_hot_level(charge_hot_level),
  .charge_cold_level(charge_cold_level),
  .source_low_level(source_low_level),
  .overcharge_level(overcharge_level),
  .charge_ready_level(charge_ready_level),
  .storage_below_overdischarge(storage_below_overdischarge),
  .irq_out(irq_out)
);

// ===== verification/efsu_host_model.sv
// efsu_host_model: host side of the serial register port.
// assumes: tasks called by the bench; drives just after a rising edge.
`timescale 1ns/100ps
module efsu_host_model (
  // clock
  input wire logic clock,
  // register port
  output efsu_pkg::efsu_byte_t reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output efsu_pkg::efsu_byte_t reg_wdata,
  input wire efsu_pkg::efsu_byte_t reg_rdata,
  input wire logic reg_rdata_valid
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    // released lines show junk, not the last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clock);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    v = reg_rdata_valid;
  endtask
endmodule

// ===== verification/efsu_event_unit_tb_top.sv
// efsu_event_unit_tb_top: self-checking bench for the event flag unit.
// assumes: host model drives the register port; bench drives monitors.
`timescale 1ns/100ps
module efsu_event_unit_tb_top;
  logic clock;
  logic rst_n;
  logic [7:0] lv;
  logic [6:0] pls;
  logic raw;
  logic prdy;
  logic ratio;
  efsu_pkg::efsu_byte_t reg_addr;
  efsu_pkg::efsu_byte_t reg_wdata;
  efsu_pkg::efsu_byte_t reg_rdata;
  logic reg_wr;
  logic reg_rd;
  logic reg_rdata_valid;
  logic irq_out;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;

  efsu_event_unit #(.CRIT_CYCLES(8)) i_efsu_event_unit (
    .clock, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .reg_rdata_valid, .irq_out,
    .aux_charger_present(lv[0]), .discharge_hot_level(lv[1]),
    .discharge_cold_level(lv[2]), .charge_hot_level(lv[3]),
    .charge_cold_level(lv[4]), .overcharge_level(lv[5]),
    .charge_ready_level(lv[6]), .source_low_level(lv[7]),
    .storage_below_overdischarge(raw), .serial_port_ready(prdy),
    .tracking_ratio_mode(ratio), .tracking_eval_begin(pls[0]),
    .tracking_eval_done(pls[1]), .storage_sample_done(pls[2]),
    .temperature_sample_done(pls[3]), .power_monitor_error(pls[4]),
    .power_monitor_window_done(pls[5]), .cv_target_below_low(pls[6])
  );

  efsu_host_model i_efsu_host_model (
    .clock, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rdata_valid
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // scenarios need under two hundred cycles; a hang ends here
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checks = checks + 1;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_total = err_total + 1;
    end
  endtask

  task automatic rdck(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    i_efsu_host_model.rd(a, d, v);
    chk("read valid", 8'h01, {7'h00, v});
    chk($sformatf("reg %h", a), e, d);
  endtask

  task automatic irqck(input logic e);
    chk("irq", {7'h00, e}, {7'h00, irq_out});
  endtask

  task automatic pulse(input int i);
    @(posedge clock);
    #1;
    pls[i] = 1'b1;
    @(posedge clock);
    #1;
    pls[i] = 1'b0;
    repeat (2) @(posedge clock);
    #1;
  endtask

  logic [7:0] ra[7] = '{8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1B, 8'h30};
  logic [7:0] rv[7] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  task automatic t_reset();
    irqck(1'b0);
    i_efsu_host_model.wr(8'h18, 8'hFF);
    foreach (rv[i]) rdck(ra[i], rv[i]);
  endtask

  task automatic t_port();
    @(posedge clock);
    #1;
    prdy = 1'b1;
    @(posedge clock);
    #1;
    irqck(1'b1);
    rdck(8'h18, 8'h01);
    irqck(1'b0);
    rdck(8'h18, 8'h00);
  endtask

  logic [7:0] pexp[5] = '{8'h01, 8'h02, 8'h10, 8'h20, 8'h80};
  task automatic t_pulses();
    pulse(3);
    rdck(8'h19, 8'h00);
    irqck(1'b0);
    i_efsu_host_model.wr(8'h16, 8'hFF);
    rdck(8'h16, 8'hF3);
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      irqck(1'b1);
      rdck(8'h19, pexp[i]);
    end
  endtask

  logic [7:0] lexp[8] = '{8'h80, 8'h40, 8'h40, 8'h20, 8'h20, 8'h08,
                          8'h04, 8'h10};
  task automatic t_levels();
    i_efsu_host_model.wr(8'h15, 8'hFF);
    rdck(8'h15, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      #1;
      lv[i] = 1'b1;
      rdck(8'h18, lexp[i]);
    end
    rdck(8'h1A, 8'h2E);
    rdck(8'h1B, 8'h0F);
    @(posedge clock);
    #1;
    lv = 8'h00;
    // source recovering is no event in ratio mode
    rdck(8'h18, 8'hEC);
    rdck(8'h1A, 8'h00);
  endtask

  task automatic t_race();
    logic [7:0] d;
    logic v;
    fork
      i_efsu_host_model.rd(8'h19, d, v);
      pulse(2);
    join
    chk("race read", 8'h00, d);
    rdck(8'h19, 8'h10);
  endtask

  task automatic t_undervolt();
    @(posedge clock);
    #1;
    raw = 1'b1;
    repeat (4) @(posedge clock);
    rdck(8'h1A, 8'h00);
    repeat (10) @(posedge clock);
    rdck(8'h1A, 8'h01);
    rdck(8'h18, 8'h02);
    @(posedge clock);
    #1;
    raw = 1'b0;
    rdck(8'h18, 8'h02);
    rdck(8'h1A, 8'h00);
  endtask

  task automatic t_window();
    i_efsu_host_model.wr(8'h14, 8'h02);
    rdck(8'h14, 8'h02);
    pulse(5);
    pulse(5);
    rdck(8'h19, 8'h00);
    pulse(5);
    rdck(8'h19, 8'h40);
    i_efsu_host_model.wr(8'h14, 8'h00);
    pulse(5);
    rdck(8'h19, 8'h40);
  endtask

  task automatic t_cv();
    pulse(6);
    rdck(8'h18, 8'h00);
    ratio = 1'b0;
    pulse(6);
    pulse(5);
    rdck(8'h18, 8'h10);
    irqck(1'b1);
    rdck(8'h19, 8'h40);
    irqck(1'b0);
  endtask

  initial begin
    rst_n = 1'b0;
    lv = 8'h00;
    pls = 7'h00;
    raw = 1'b0;
    prdy = 1'b0;
    ratio = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_port();
    t_pulses();
    t_levels();
    t_race();
    t_undervolt();
    t_window();
    t_cv();
    end_sim();
  end
endmodule
